// ===== hw/scw_regs.svh
// Register offsets, field positions, reset values and widths of the control word.
//
// Behaviour
// R1 - Reset input low forces every control bit to zero, whatever the serial lines do.
// R2 - A word shifted in while reset is low is discarded, never stored or applied.
// R3 - After reset release the word stays zero until a complete new word is latched.
// R4 - The controller may pull reset low any time, then must rewrite its settings.
// R5 - Mic silence bit one mutes the microphone amplifier; zero gives normal gain.
// R6 - While power-down is high the serial port ignores clock, data and strobe.
// R7 - Leaving power-down clears all eight control bits to zero.
// R8 - Strobe low, eight bits first-bit-first on rising clock; strobe rising applies word.
// R9 - Low four bits volume, bit five range, top two bits operating mode.
// R10 - With a running clock the controller raises the strobe before the next edge.
// R11 - Both clears act on shift stage and applied outputs; zero means defaults.
`ifndef SCW_REGS_SVH
`define SCW_REGS_SVH

`define SCW_OFS_WORD      12'h000
`define SCW_OFS_STATUS    12'h004
`define SCW_OFS_CTRL      12'h008

`define SCW_WORD_BITS     8
`define SCW_CNT_BITS      4
`define SCW_CNT_FULL      4'h8
`define SCW_CNT_MAX       4'hf
`define SCW_WORD_RESET    8'h00

`define SCW_VOL_LSB       0
`define SCW_VOL_MSB       3
`define SCW_MUTE_BIT      4
`define SCW_RANGE_BIT     5
`define SCW_MODE_LSB      6
`define SCW_MODE_MSB      7

`define SCW_CTRL_EN_BIT   0
`define SCW_CTRL_RESET    1'b1
`define SCW_ST_PD_BIT     0
`define SCW_ST_OK_LSB     8
`define SCW_ST_BAD_LSB    16
`define SCW_CNT_W         8

`endif

// ===== hw/scw_pkg.sv
// Types shared by the control word logic.
package scw_pkg;

    typedef enum logic [1:0] {
        SCW_MODE_VOICE  = 2'h0,
        SCW_MODE_RX     = 2'h1,
        SCW_MODE_IDLE_A = 2'h2,
        SCW_MODE_IDLE_B = 2'h3
    } scw_mode_t;

    typedef struct packed {
        logic [3:0] volumeField;
        logic       micSilenceBit;
        logic       rangeSelectBit;
        scw_mode_t  opMode;
    } scw_ctrl_t;

    typedef struct packed {
        logic [7:0] word;
        logic [3:0] count;
    } scw_link_t;

endpackage : scw_pkg

// ===== hw/scw_link_shift.sv
// Serial-clock side shifter of the control word.
`timescale 1ns/100ps
`include "scw_regs.svh"
module scw_link_shift
    import scw_pkg::*;
(
    // Serial link
    input  wire logic       serialClk,
    input  wire logic       serialData,
    input  wire logic       wordLatchStrobe,
    // Clears
    input  wire logic       arst_n,
    input  wire logic       powerDownPin,
    // Captured frame
    output scw_link_t       linkOut
);

    logic [7:0] word_r;
    logic [7:0] word_nxt;
    logic [3:0] count_r;
    logic [3:0] count_nxt;
    logic       started_r;
    logic       started_nxt;
    logic       linkClr;
    logic       frameClr;

    // R2 shift discard, R6 port blocked
    assign linkClr  = ~arst_n | powerDownPin;
    // The strobe itself ends a frame, since the clock may stop after it.
    // Only the start marker is cleared by it: the count must still stand
    // when the system side sees the synchronised strobe rise.
    assign frameClr = linkClr | wordLatchStrobe;

    always_comb
    begin
        word_nxt    = word_r;
        count_nxt   = count_r;
        started_nxt = started_r;
        // R8 first bit first
        if (!wordLatchStrobe)
        begin
            word_nxt    = {word_r[6:0], serialData};
            started_nxt = 1'b1;
            if (!started_r)
            begin
                count_nxt = 4'h1;
            end
            else if (count_r != `SCW_CNT_MAX)
            begin
                count_nxt = count_r + 4'h1;
            end
        end
    end

    always_ff @(posedge serialClk or posedge frameClr)
    begin
        if (frameClr)
            started_r <= 1'b0;
        else
            started_r <= started_nxt;
    end

    // R11 shift stage clear
    always_ff @(posedge serialClk or posedge linkClr)
    begin
        if (linkClr)
            word_r <= `SCW_WORD_RESET;
        else
            word_r <= word_nxt;
    end

    // A strobe pulse with no clock edges sees the last count again and
    // reapplies the word that is already held; this is harmless.
    always_ff @(posedge serialClk or posedge linkClr)
    begin
        if (linkClr)
            count_r <= 4'h0;
        else
            count_r <= count_nxt;
    end

    assign linkOut.word  = word_r;
    assign linkOut.count = count_r;

endmodule : scw_link_shift

// ===== hw/scw_ctrl_word.sv
// Control word register: serial entry, reset and power-down clears, APB view.
`timescale 1ns/100ps
`include "scw_regs.svh"
module scw_ctrl_word
    import scw_pkg::*;
(
    // System clock and power-on reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Serial control port
    input  wire logic        serialClk,
    input  wire logic        serialData,
    input  wire logic        wordLatchStrobe,
    input  wire logic        powerDownPin,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Applied control outputs
    output logic [3:0]       volumeField,
    output logic             micSilenceBit,
    output logic             rangeSelectBit,
    output scw_mode_t        opMode,
    output logic             micMuted
);

    typedef struct packed {
        logic [2:0] strbSync;
        logic       strbStable;
        logic [2:0] pdSync;
        logic       pdStable;
        logic [7:0] word;
        logic       portEn;
        logic [7:0] okCnt;
        logic [7:0] badCnt;
        logic [31:0] rdata;
        logic       slvErr;
    } scw_state_t;

    scw_state_t s_r;
    scw_state_t s_nxt;
    scw_link_t  linkIn;
    logic       strobeRise;
    logic       setupPhase;
    logic       accessPhase;
    logic       frameFull;

    scw_link_shift u_link_shift (
        .serialClk       (serialClk),
        .serialData      (serialData),
        .wordLatchStrobe (wordLatchStrobe),
        .arst_n          (arst_n),
        .powerDownPin    (powerDownPin),
        .linkOut         (linkIn)
    );

    function automatic logic isMapped(input logic [11:0] addr);
        isMapped = (addr == `SCW_OFS_WORD) ||
                   (addr == `SCW_OFS_STATUS) ||
                   (addr == `SCW_OFS_CTRL);
    endfunction : isMapped

    function automatic logic [31:0] readValue(
        input logic [11:0] addr,
        input scw_state_t  st
    );
        logic [31:0] v;
        v = 32'h0;
        unique case (addr)
            `SCW_OFS_WORD:
            begin
                v[7:0] = st.word;
            end
            `SCW_OFS_STATUS:
            begin
                v[`SCW_ST_PD_BIT] = st.pdStable;
                v[`SCW_ST_OK_LSB +: `SCW_CNT_W] = st.okCnt;
                v[`SCW_ST_BAD_LSB +: `SCW_CNT_W] = st.badCnt;
            end
            `SCW_OFS_CTRL:
            begin
                v[`SCW_CTRL_EN_BIT] = st.portEn;
            end
            default:
            begin
                v = 32'h0;
            end
        endcase
        readValue = v;
    endfunction : readValue

    assign setupPhase  = psel & ~penable;
    assign accessPhase = psel & penable;

    // A change of a pin counts once the second and third stages agree.
    assign strobeRise = s_r.strbSync[1] & s_r.strbSync[2] &
                        ~s_r.strbStable;

    // The shifter is quiet while the strobe is high, so its word and
    // count are stable by the time the synchronised rise is seen here.
    assign frameFull = (linkIn.count >= `SCW_CNT_FULL);

    always_comb
    begin
        s_nxt = s_r;

        s_nxt.strbSync = {s_r.strbSync[1:0], wordLatchStrobe};
        if (s_r.strbSync[1] == s_r.strbSync[2])
        begin
            s_nxt.strbStable = s_r.strbSync[2];
        end

        s_nxt.pdSync = {s_r.pdSync[1:0], powerDownPin};
        if (s_r.pdSync[1] == s_r.pdSync[2])
        begin
            s_nxt.pdStable = s_r.pdSync[2];
        end

        // R8 apply on strobe rise
        if (strobeRise && !s_r.pdStable && s_r.portEn)
        begin
            // R3 only a full word
            if (frameFull)
            begin
                s_nxt.word  = linkIn.word;
                s_nxt.okCnt = s_r.okCnt + 8'h1;
            end
            else
            begin
                s_nxt.badCnt = s_r.badCnt + 8'h1;
            end
        end

        // R6 port held off
        if (s_r.pdStable)
        begin
            s_nxt.word = `SCW_WORD_RESET;
        end

        // R7 clear on re-enable
        if (s_r.pdStable && !s_nxt.pdStable)
        begin
            s_nxt.word = `SCW_WORD_RESET;
        end

        if (setupPhase)
        begin
            s_nxt.rdata  = readValue(paddr, s_r);
            s_nxt.slvErr = ~isMapped(paddr);
        end

        if (accessPhase && pwrite && paddr == `SCW_OFS_CTRL)
        begin
            s_nxt.portEn = pwdata[`SCW_CTRL_EN_BIT];
        end
    end

    // R1 async clear
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r.strbSync   <= 3'h7;
            s_r.strbStable <= 1'b1;
            s_r.pdSync     <= 3'h0;
            s_r.pdStable   <= 1'b0;
            // R11 applied outputs zero
            s_r.word       <= `SCW_WORD_RESET;
            s_r.portEn     <= `SCW_CTRL_RESET;
            s_r.okCnt      <= 8'h0;
            s_r.badCnt     <= 8'h0;
            s_r.rdata      <= 32'h0;
            s_r.slvErr     <= 1'b0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Zero wait states: the read value was captured in the setup cycle.
    assign pready  = accessPhase;
    assign prdata  = s_r.rdata;
    assign pslverr = accessPhase & s_r.slvErr;

    // R9 field decode
    assign volumeField    = s_r.word[`SCW_VOL_MSB:`SCW_VOL_LSB];
    assign rangeSelectBit = s_r.word[`SCW_RANGE_BIT];
    assign opMode         =
        scw_mode_t'(s_r.word[`SCW_MODE_MSB:`SCW_MODE_LSB]);
    assign micSilenceBit  = s_r.word[`SCW_MUTE_BIT];

    // R5 microphone mute
    assign micMuted = s_r.word[`SCW_MUTE_BIT];

endmodule : scw_ctrl_word

// ===== verification/scw_ctrl_word_properties.sv
// Concurrent checks on the ports of the control word register.
`timescale 1ns/100ps
module scw_ctrl_word_properties
    import scw_pkg::*;
(
    // Clock, reset and inputs
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire logic        wordLatchStrobe,
    input wire logic        powerDownPin,
    input wire logic        psel,
    input wire logic        penable,
    // Outputs
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  volumeField,
    input wire logic        micSilenceBit,
    input wire logic        rangeSelectBit,
    input wire scw_mode_t   opMode,
    input wire logic        micMuted
);
    logic [7:0] word;
    assign word = {opMode, rangeSelectBit, micSilenceBit, volumeField};
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    reset_zero_a: assert property ($rose(arst_n) |-> word == 8'h00)
        else $error("word not clear after reset");
    mute_drive_a: assert property (micMuted == micSilenceBit)
        else $error("mute drive differs from its bit");
    word_hold_a: assert property ($changed(word) |-> word == 8'h00
        || $past(wordLatchStrobe, 2)) else $error("word moved unlatched");
    pd_hold_a: assert property (powerDownPin [*6] |-> word == 8'h00)
        else $error("word not held clear in power-down");
    pd_exit_a: assert property (powerDownPin [*6] ##1 !powerDownPin
        |-> (word == 8'h00) [*3]) else $error("word not clear on resume");
    ready_a: assert property (pready == (psel && penable))
        else $error("ready not tied to access phase");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response carries data");
    err_setup_a: assert property (pslverr |-> $past(psel) && !$past(penable))
        else $error("error without a setup cycle");
    cover property ($changed(word) && word != 8'h00);
    cover property (powerDownPin [*6] ##1 !powerDownPin);
    cover property (pslverr);
endmodule : scw_ctrl_word_properties

bind scw_ctrl_word scw_ctrl_word_properties i_props (.*);

// ===== verification/scw_serial_host.sv
// Behavioural microcontroller on the three-wire serial control port.
`timescale 1ns/100ps
module scw_serial_host
(
    // Serial control lines
    output logic serialClk,
    output logic serialData,
    output logic wordLatchStrobe
);
    initial {serialClk, serialData, wordLatchStrobe} = 3'h1;
    // Shifts the low n bits of w; hp is the half period, t the tail clocks.
    task send(input logic [15:0] w, input int n, hp, t);
        // strobe low, first bit first, shifted on rising edges
        #0.7 wordLatchStrobe = 1'h0;
        for (int i = n - 1; i >= 0; i--)
        begin
            #(hp) serialClk = 1'h0;
            serialData = w[i];
            #(hp) serialClk = 1'h1;
        end
        #(hp) serialClk = 1'h0;
        // strobe high before any further rise; data line inverted
        #(hp / 2) {wordLatchStrobe, serialData} = {1'h1, ~serialData};
        repeat (t)
        begin
            #(hp) serialClk = 1'h1;
            #(hp) serialClk = 1'h0;
        end
        #(hp);
    endtask : send
endmodule : scw_serial_host

// ===== verification/tb_top.sv
// Self-checking bench for the serial control word register.
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    failures++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top
    import scw_pkg::*;
;
    logic        mclk = 1'h0, arst_n = 1'h0, powerDownPin = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, micSilenceBit, rangeSelectBit, micMuted;
    logic        serialClk, serialData, wordLatchStrobe;
    logic [3:0]  volumeField;
    scw_mode_t   opMode;
    int          failures = 0, check_count = 0;
    wire [7:0]   word = {opMode, rangeSelectBit, micSilenceBit, volumeField};
    scw_ctrl_word   i_dut (.*);
    scw_serial_host i_host (.*);
    always #2 mclk = ~mclk;
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge mclk);
        penable <= 1'h1;
        do
            @(posedge mclk);
        while (pready !== 1'h1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask : apb
    // Sends n bits (none if n is 0), then reads the word back.
    task look(input logic [15:0] w, input int n, t, input logic [7:0] e);
        if (n > 0)
            i_host.send(w, n, 16, t);
        repeat (8) @(posedge mclk);
        apb(1'h0, 12'h000, 32'h0);
        `CHK("word register", {24'h0, e}, rd)
        `CHK("control pins", e, word)
    endtask : look
    task t_modes;
        logic [7:0] tbl [4] = '{8'h15, 8'h6a, 8'hb3, 8'hfc};
        foreach (tbl[i])
        begin
            look({8'h00, tbl[i]}, 8, i % 2, tbl[i]);
            `CHK("mute", tbl[i][4], micMuted)
        end
    endtask : t_modes
    task t_short;
        look(16'h0003, 5, 0, 8'hfc);
        look(16'h2c5a, 10, 1, 8'h5a);
        apb(1'h0, 12'h004, 32'h0);
        `CHK("frame counts", 16'h0105, rd[23:8])
    endtask : t_short
    task t_reset_mid;
        // the controller pulls reset low while sending
        arst_n <= 1'h0;
        i_host.send(16'h0033, 8, 16, 0);
        @(posedge mclk);
        arst_n <= 1'h1;
        look(16'h0, 0, 0, 8'h00);
        look(16'h0033, 4, 0, 8'h00);
    endtask : t_reset_mid
    task t_pd;
        look(16'h0077, 8, 0, 8'h77);
        powerDownPin <= 1'h1;
        look(16'h0041, 8, 0, 8'h00);
        apb(1'h0, 12'h004, 32'h0);
        `CHK("status", 16'h0101, rd[15:0])
        powerDownPin <= 1'h0;
        look(16'h0, 0, 0, 8'h00);
    endtask : t_pd
    task t_apb;
        apb(1'h1, 12'h000, 32'hff);
        apb(1'h1, 12'h008, 32'h0);
        look(16'h0055, 8, 0, 8'h00);
        apb(1'h1, 12'h008, 32'h1);
        apb(1'h0, 12'h00c, 32'h0);
        `CHK("bad address", 33'h1_0000_0000, {err, rd})
    endtask : t_apb
    task summarize;
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'h1;
        look(16'h0, 0, 0, 8'h00);
        t_modes;
        t_short;
        t_reset_mid;
        t_pd;
        t_apb;
        summarize;
    end
    initial
    begin
        #100000;
        failures++;
        summarize;
    end
endmodule : tb_top
